/* test/tb_ocr_osc_regs.sv */
// self-checking bench for the oscillator configuration registers
module tb_ocr_osc_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import ocr_pkg::*;
    logic        clk_sys = 0, rst_b = 0, hsel = 0, hwrite = 0, por = 1, sosc;
    logic        hreadyout, irq, cSos, rdPhase = 0, beatOn = 1, beat = 0;
    logic [1:0]  htrans = 0, csm = 0, cBus;
    logic [2:0]  hsize = 3'h2, cPll, cMul, cNew, cs, currentSourceSelect;
    logic [8:0]  pllDivideRatio;
    logic [3:0]  periphDivideRatio;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, e, v, ex, mk, q[$], mq[$];
    int          err_total = 0, checks = 0, cyc = 0, seed;

    ocr_osc_regs #(.FAIL_CYC(8), .SETTLE_CYC(2)) dut_u (
        .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
        .powerOnReset(por), .cfgPllOutputDivider(cPll),
        .cfgPeriphBusClockDivisor(cBus), .cfgPllMultiplier(cMul),
        .cfgNewSourceSelect(cNew), .cfgSecondaryOscEnable(cSos),
        .cfgClockSwitchMonitor(csm), .secondaryOscReadyPin(sosc),
        .pllLockPin(1'b1), .usbPllLockPin(1'b0), .refclkActivePin(sosc),
        .activeClockBeat(beat), .pllOutputDivider(), .pllDivideRatio(pllDivideRatio),
        .fastRcDivider(), .periphBusClockDivisor(),
        .periphDivideRatio(periphDivideRatio), .pllMultiplier(),
        .currentSourceSelect(currentSourceSelect), .secondaryOscEnable(),
        .usbFastRcEnable(), .sleepOnWaitEnable(), .fastRcTune(),
        .refclkDivisor(), .refclkEnable(), .refclkStopInIdle(),
        .refclkOutputEnable(), .refclkRunInSleep(), .refclkSourceSelect(),
        .refclkTrim(), .irq(irq));

    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    // the beat stands for the running source; stopping it fakes a failure
    // each level held two cycles, or the pin filter never passes it
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (beatOn && cyc[0]) beat <= ~beat;
        if (cyc == 5000) begin
            err_total++;
            report_and_stop;
        end
        if (rdPhase && hreadyout === 1'b1) begin
            ex = q.pop_front();
            mk = mq.pop_front();
            cmp("hrdata", ex & mk, hrdata & mk);
        end
    end

    task cmp(input string n, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask
    // master waits on hready; only the cycle ceiling ends a hang
    task xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
              input logic [31:0] m);
        @(posedge clk_sys);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= {16'h0, a};
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= w ? d : $urandom;
        if (!w) begin
            q.push_back(d);
            mq.push_back(m);
            rdPhase <= 1;
        end
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rdPhase <= 0;
    endtask
    task wr(input logic [15:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 32'h0);
    endtask
    task rst(input logic p);
        rst_b <= 0;
        por <= p;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1;
        repeat (4) @(posedge clk_sys);
    endtask
    task report_and_stop;
        if (err_total == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        seed = $urandom(32'h1c07);
        {cPll, cBus, cMul, cNew, cSos, sosc} = 13'($urandom);
        rst(1'b1);
        xfer(0, OFS_OSC_CTRL, {2'h0, cPll, 3'h1, 1'b0, sosc, 1'b0, cBus,
             cMul, 1'b0, cNew, 1'b0, cNew, 6'h0, cSos, 1'b0},
             32'hff5f_ff03);
        rst(1'b0);
        xfer(0, OFS_OSC_CTRL, {2'h0, 6'h09, 1'b0, sosc, 1'b0, 5'h18,
             1'b0, cNew, 1'b0, cNew, 8'h0}, 32'hff5f_ff03);
        xfer(0, OFS_REF_CTRL, {23'h0, sosc, 8'h0}, 32'hffff_ffff);
        wr(OFS_OSC_CTRL, 32'hc000_8800);
        xfer(0, OFS_OSC_CTRL, 32'h0, 32'hc000_8800);
        wr(16'hf060, 32'hffff_ffff);
        xfer(0, 16'hf060, 32'h0, 32'hffff_ffff);
        e = 0;
        for (int i = 0; i < 12; i++) begin
            v = $urandom;
            wr(OFS_FRC_TUNE + 16'(4 * (i % 4)), v);
            case (i % 4)
                0: e = v;
                1: e = e & ~v;
                2: e = e | v;
                default: e = e ^ v;
            endcase
            e = e & TUNE_WMASK;
            xfer(0, OFS_FRC_TUNE, e, 32'hffff_ffff);
        end
        for (int i = 0; i < 8; i++) begin
            wr(OFS_OSC_CTRL, (i << 27) | ((i % 4) << 19));
            repeat (12) @(posedge clk_sys);
            cmp("pllRatio", (i == 7) ? 256 : 1 << i, 32'(pllDivideRatio));
            cmp("pbRatio", 1 << (i % 4), 32'(periphDivideRatio));
        end
        wr(OFS_OSC_CTRL + 16'h8, 32'h10);
        xfer(0, OFS_OSC_CTRL, 32'h10, 32'h10);
        wr(OFS_OSC_CTRL + 16'h4, 32'h10);
        xfer(0, OFS_OSC_CTRL, 32'h0, 32'h10);
        wr(OFS_IRQ_MASK, 32'h3);
        cs = cNew;
        for (int i = 0; i < 8; i++) begin
            wr(OFS_OSC_CTRL, (i << 8) | 1);
            @(negedge clk_sys);
            cmp("srcEarly", 32'(cs), 32'(currentSourceSelect));
            cs = 3'(i);
            repeat (60) if (irq !== 1'b1) @(posedge clk_sys);
            xfer(0, OFS_OSC_CTRL, i << 12, 32'h0000_7001);
            cmp("irqDone", 32'h1, 32'(irq));
            wr(OFS_IRQ_STAT, 32'h1);
            @(negedge clk_sys);
            cmp("irqClear", 32'h0, 32'(irq));
        end
        beatOn <= 0;
        repeat (60) if (irq !== 1'b1) @(posedge clk_sys);
        xfer(0, OFS_OSC_CTRL, 32'h8, 32'h0000_7008);
        xfer(0, OFS_IRQ_STAT, 32'h2, 32'h2);
        report_and_stop;
    end
endmodule

/* verilog/ocr_osc_regs.sv */
// oscillator configuration registers behind an AHB-Lite slave
// Functional notes
// RULE1 - pll output divider codes 0..7 divide by 1,2,4,8,16,32,64,256
// RULE2 - control register bits 31 and 30 always read zero
// RULE3 - base plus 4, 8, 12 clear, set, invert the written ones
// RULE4 - control reset contents follow config words and reset kind
// RULE5 - power-on reset loads dividers, multiplier, new source, sosc enable
// RULE6 - usb fast rc enable exists only on usb variants
// RULE7 - unimplemented positions read zero; unknown fields get a value
// RULE8 - reference control low half: on, idle, oe, sleep, divsw, active, sel
// RULE9 - fail-safe monitor detects loss of the active clock
// RULE10 - software switches sources; pll has divider and multiplier
// RULE11 - writing switch request starts switch; hardware clears when done
// RULE12 - source codes 0..7: frc, frc pll, pri, pri pll, sec, lprc, ...
// RULE13 - clock fail flag reads one after a detected failure
// RULE14 - bus divisor written only while ready; divides by 1,2,4,8
// RULE15 - writes to unimplemented bits ignored, they keep reading zero
// RULE16 - current source is read-only and changes only on completion; here it also moves to frc on failover and to the new source on config load
//
// Design decision made here: the AHB-Lite slave port.
module ocr_osc_regs #(
    parameter bit HAS_USB    = 1'b1,
    parameter int FAIL_CYC   = ocr_pkg::FAIL_CYC,
    parameter int SETTLE_CYC = ocr_pkg::SETTLE_CYC
)(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        powerOnReset,
    input  wire logic [2:0]  cfgPllOutputDivider,
    input  wire logic [1:0]  cfgPeriphBusClockDivisor,
    input  wire logic [2:0]  cfgPllMultiplier,
    input  wire logic [2:0]  cfgNewSourceSelect,
    input  wire logic        cfgSecondaryOscEnable,
    input  wire logic [1:0]  cfgClockSwitchMonitor,
    input  wire logic        secondaryOscReadyPin,
    input  wire logic        pllLockPin,
    input  wire logic        usbPllLockPin,
    input  wire logic        refclkActivePin,
    input  wire logic        activeClockBeat,
    output logic [2:0]       pllOutputDivider,
    output logic [8:0]       pllDivideRatio,
    output logic [2:0]       fastRcDivider,
    output logic [1:0]       periphBusClockDivisor,
    output logic [3:0]       periphDivideRatio,
    output logic [2:0]       pllMultiplier,
    output logic [2:0]       currentSourceSelect,
    output logic             secondaryOscEnable,
    output logic             usbFastRcEnable,
    output logic             sleepOnWaitEnable,
    output logic [5:0]       fastRcTune,
    output logic [14:0]      refclkDivisor,
    output logic             refclkEnable,
    output logic             refclkStopInIdle,
    output logic             refclkOutputEnable,
    output logic             refclkRunInSleep,
    output logic [3:0]       refclkSourceSelect,
    output logic [8:0]       refclkTrim,
    output logic             irq
);
    import ocr_pkg::*;
    localparam int FW = $clog2(FAIL_CYC + 1);
    localparam int PW = $clog2(PB_CYC + 1);

    if (FAIL_CYC < 2) begin : g_bad
        $error("fail timeout must be at least two cycles");
    end

    function automatic logic [31:0] aliasOp(
        input logic [31:0] old,
        input logic [31:0] w,
        input logic [1:0]  al,
        input logic [31:0] m
    );
        logic [31:0] wm;
        wm = w & m;
        unique case (al)
            AL_PLAIN: aliasOp = (old & ~m) | wm;
            AL_CLR:   aliasOp = old & ~wm;
            AL_SET:   aliasOp = old | wm;
            AL_INV:   aliasOp = old ^ wm;
        endcase
    endfunction

    // bus pipeline
    logic        dpValid_q;
    logic        dpWrite_q;
    logic [15:0] dpAddr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rdMux;
    // register state
    logic        cfgLoad_q;
    logic [31:0] oscCtl_q;
    logic [31:0] oscCtl_d;
    logic [5:0]  tune_q;
    logic [31:0] refCtl_q;
    logic [31:0] refCtl_d;
    logic [31:0] trim_q;
    logic [1:0]  stat_q;
    logic [1:0]  mask_q;
    logic [PW-1:0] pbCnt_q;
    logic [FW-1:0] failCnt_q;
    logic        beatPrev_q;
    logic [8:0]  pllRatio_q;
    logic [3:0]  pbRatio_q;
    // pin synchronisers
    logic [4:0]  s1_q;
    logic [4:0]  s2_q;
    logic [4:0]  s3_q;
    logic [4:0]  clean_q;

    ocr_switch_if swIf ();

    ocr_src_switch #(
        .SETTLE_CYC (SETTLE_CYC)
    ) u_switch (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .sw      (swIf.ctrl)
    );

    // address phase capture; zero wait states, always OKAY
    wire accept  = hsel && htrans[1] && hready;
    wire isWord  = hsize == 3'h2;
    wire [11:0] wBlk = dpAddr_q[15:4];
    wire [1:0]  wAl  = dpAddr_q[3:2];
    wire [11:0] rBlk = haddr[15:4];
    wire [1:0]  rAl  = haddr[3:2];
    wire wrEn   = dpValid_q && dpWrite_q && !cfgLoad_q;
    wire wrOsc  = wrEn && wBlk == OFS_OSC_CTRL[15:4];
    wire wrTune = wrEn && wBlk == OFS_FRC_TUNE[15:4];
    wire wrRef  = wrEn && wBlk == OFS_REF_CTRL[15:4];
    wire wrTrim = wrEn && wBlk == OFS_REF_TRIM[15:4];
    wire wrStat = wrEn && dpAddr_q == OFS_IRQ_STAT;
    wire wrMask = wrEn && dpAddr_q == OFS_IRQ_MASK;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dpValid_q <= 1'b0;
            dpWrite_q <= 1'b0;
            dpAddr_q  <= '0;
        end else begin
            dpValid_q <= accept && (isWord || !hwrite);
            dpWrite_q <= hwrite;
            dpAddr_q  <= haddr[15:0];
        end
    end

    // synchronised pins: sosc ready, pll lock, usb lock, active, beat
    wire [4:0] pinIn = {activeClockBeat, refclkActivePin, usbPllLockPin,
                        pllLockPin, secondaryOscReadyPin};
    wire [4:0] agree = ~(s2_q ^ s3_q);
    wire secondary_osc_ready  = clean_q[0];
    wire pllLock  = clean_q[1];
    wire usbLock  = clean_q[2] && HAS_USB;
    wire refAct   = clean_q[3];
    wire beat     = clean_q[4];

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s1_q    <= '0;
            s2_q    <= '0;
            s3_q    <= '0;
            clean_q <= '0;
        end else begin
            s1_q    <= pinIn;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            clean_q <= (agree & s3_q) | (~agree & clean_q);
        end
    end

    // RULE9 heartbeat watchdog on the active source
    wire monEn    = cfgClockSwitchMonitor == 2'b00 && !cfgLoad_q;
    wire beatEdge = beat != beatPrev_q;
    wire failPulse = monEn && !beatEdge
                     && failCnt_q == FW'(FAIL_CYC - 1);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            beatPrev_q <= 1'b0;
            failCnt_q  <= '0;
        end else begin
            beatPrev_q <= beat;
            failCnt_q  <= (beatEdge || failPulse || !monEn)
                          ? '0 : failCnt_q + 1'b1;
        end
    end

    // lock only bites when switching is disabled by configuration
    wire swDisabled = cfgClockSwitchMonitor[1];
    wire lockEff    = oscCtl_q[P_LOCK] && swDisabled;
    wire pbRdy      = pbCnt_q == '0;

    // RULE15 writable mask drops unimplemented and guarded bits
    // RULE6 usb enable masked on parts without usb
    // RULE14 divisor bits masked while not ready
    wire [31:0] oscWm = OSC_WMASK
        & ~(HAS_USB ? 32'h0 : (32'h1 << P_UFRC))
        & ~(lockEff ? LOCK_MASK : 32'h0)
        & ~(swDisabled ? 32'h1 : 32'h0)
        & ~(pbRdy ? 32'h0 : PERIPH_BUS_CLOCK_DIVISOR_MASK);

    // RULE2 RULE7 read view: status bits ored in, the rest zero
    wire [31:0] oscRd = oscCtl_q
        | {9'h0, secondary_osc_ready, pbRdy, 21'h0}
        | {17'h0, swIf.curSrc, 12'h0}
        | {25'h0, usbLock, pllLock, 5'h0};
    wire [31:0] oscNew = aliasOp(oscRd, hwdata, wAl, oscWm);
    wire pbWrite = wrOsc && pbRdy
        && oscNew[P_PERIPH_BUS_CLOCK_DIVISOR +: 2] != oscCtl_q[P_PERIPH_BUS_CLOCK_DIVISOR +: 2];

    // RULE4 RULE5 configuration load in the first cycle after reset
    always_comb begin
        oscCtl_d = oscCtl_q;
        if (cfgLoad_q) begin
            oscCtl_d = REG_RST;
            oscCtl_d[P_PLL_OUTPUT_DIVIDER +: 3] = powerOnReset
                ? cfgPllOutputDivider : RST_PLL_OUTPUT_DIVIDER;
            oscCtl_d[P_FAST_RC_DIVIDER +: 3]  = RST_FAST_RC_DIVIDER;
            oscCtl_d[P_PERIPH_BUS_CLOCK_DIVISOR +: 2]   = powerOnReset
                ? cfgPeriphBusClockDivisor : RST_PERIPH_BUS_CLOCK_DIVISOR;
            oscCtl_d[P_PLL_MULTIPLIER +: 3] = powerOnReset
                ? cfgPllMultiplier : RST_PLL_MULTIPLIER;
            oscCtl_d[P_NEW_SOURCE_SELECT +: 3]    = cfgNewSourceSelect;
            oscCtl_d[P_SECONDARY_OSC_ENABLE]       = powerOnReset && cfgSecondaryOscEnable;
        end else begin
            // RULE3 alias writes on the control register
            if (wrOsc) oscCtl_d = oscNew & OSC_WMASK;
            // RULE11 hardware clear on completion, a write set wins
            if (!(wrOsc && oscNew[P_SOURCE_SWITCH_REQUEST]) && (swIf.done || failPulse))
                oscCtl_d[P_SOURCE_SWITCH_REQUEST] = 1'b0;
            // RULE13 failure sets the flag over any clearing write
            if (failPulse) oscCtl_d[P_CF] = 1'b1;
        end
    end

    // RULE8 reference control; divisor switch self-clears while on
    wire [31:0] refRd  = refCtl_q | {23'h0, refAct, 8'h0};
    wire [31:0] refNew = aliasOp(refRd, hwdata, wAl, REF_WMASK);
    always_comb begin
        refCtl_d = refCtl_q;
        if (refCtl_q[P_DIVSW] && refCtl_q[P_RON])
            refCtl_d[P_DIVSW] = 1'b0;
        if (wrRef) refCtl_d = refNew & REF_WMASK;
    end

    wire [31:0] tuneRd  = {26'h0, tune_q};
    wire [31:0] tuneNew = aliasOp(tuneRd, hwdata, wAl, TUNE_WMASK);
    wire [31:0] trimNew = aliasOp(trim_q, hwdata, wAl, TRIM_WMASK);
    wire [1:0]  events  = {failPulse, swIf.done};
    wire [1:0]  statClr = wrStat ? hwdata[1:0] : 2'h0;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cfgLoad_q <= 1'b1;
            oscCtl_q  <= REG_RST;
            refCtl_q  <= REG_RST;
        end else begin
            cfgLoad_q <= 1'b0;
            oscCtl_q  <= oscCtl_d;
            refCtl_q  <= refCtl_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tune_q <= '0;
            trim_q <= REG_RST;
            mask_q <= '0;
        end else begin
            if (wrTune) tune_q <= tuneNew[5:0];
            if (wrTrim) trim_q <= trimNew & TRIM_WMASK;
            if (wrMask) mask_q <= hwdata[1:0];
        end
    end

    // status bits: a new event wins over a write-one clear
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) stat_q <= '0;
        else stat_q <= (stat_q & ~statClr) | events;
    end

    assign irq = |(stat_q & mask_q);

    // RULE14 divisor ready drops for a settle time after a change
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) pbCnt_q <= '0;
        else if (pbWrite) pbCnt_q <= PW'(PB_CYC);
        else if (!pbRdy) pbCnt_q <= pbCnt_q - 1'b1;
    end

    // RULE1 RULE14 decoded ratios, registered
    wire [2:0] odiv = oscCtl_q[P_PLL_OUTPUT_DIVIDER +: 3];
    wire [1:0] pdiv = oscCtl_q[P_PERIPH_BUS_CLOCK_DIVISOR +: 2];
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pllRatio_q <= 9'h001;
            pbRatio_q  <= 4'h1;
        end else begin
            pllRatio_q <= (odiv == 3'h7) ? 9'h100 : 9'h001 << odiv;
            pbRatio_q  <= 4'h1 << pdiv;
        end
    end

    // read mux; aliases read back their base register, except status and mask aliases read zero
    always_comb begin
        rdMux = 32'h0;
        unique case (rBlk)
            OFS_OSC_CTRL[15:4]: rdMux = oscRd;
            OFS_FRC_TUNE[15:4]: rdMux = tuneRd;
            OFS_REF_CTRL[15:4]: rdMux = refRd;
            OFS_REF_TRIM[15:4]: rdMux = trim_q;
            OFS_IRQ_STAT[15:4]: rdMux = (rAl == 2'h0) ? {30'h0, stat_q}
                                                      : 32'h0;
            OFS_IRQ_MASK[15:4]: rdMux = (rAl == 2'h0) ? {30'h0, mask_q}
                                                      : 32'h0;
            default:            rdMux = 32'h0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) hrdata_q <= '0;
        else if (accept && !hwrite) hrdata_q <= rdMux;
    end

    // RULE10 RULE12 switch request hand-off, target from new source
    assign swIf.start     = oscCtl_q[P_SOURCE_SWITCH_REQUEST] && !swIf.busy;
    assign swIf.target    = oscCtl_q[P_NEW_SOURCE_SELECT +: 3];
    assign swIf.failover  = failPulse;
    assign swIf.pllLocked = pllLock;
    assign swIf.load      = cfgLoad_q;
    assign swIf.loadSrc   = cfgNewSourceSelect;

    assign pllOutputDivider      = odiv;
    assign pllDivideRatio        = pllRatio_q;
    assign fastRcDivider         = oscCtl_q[P_FAST_RC_DIVIDER +: 3];
    assign periphBusClockDivisor = pdiv;
    assign periphDivideRatio     = pbRatio_q;
    assign pllMultiplier         = oscCtl_q[P_PLL_MULTIPLIER +: 3];
    assign currentSourceSelect   = swIf.curSrc;
    assign secondaryOscEnable    = oscCtl_q[P_SECONDARY_OSC_ENABLE];
    assign usbFastRcEnable       = oscCtl_q[P_UFRC];
    assign sleepOnWaitEnable     = oscCtl_q[P_SLEEP_ON_WAIT_ENABLE];
    assign fastRcTune            = tune_q;
    assign refclkDivisor         = refCtl_q[P_REFCLK_DIVISOR +: 15];
    assign refclkEnable          = refCtl_q[P_RON];
    assign refclkStopInIdle      = refCtl_q[P_RSIDL];
    assign refclkOutputEnable    = refCtl_q[P_ROE];
    assign refclkRunInSleep      = refCtl_q[P_RRSLP];
    assign refclkSourceSelect    = refCtl_q[3:0];
    assign refclkTrim            = trim_q[P_REFCLK_TRIM +: 9];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_oscAlias(logic [1:0] al);
        wrOsc && wAl == al && hwdata[P_SLEEP_ON_WAIT_ENABLE];
    endsequence

    chk_div_ratio: assert property ( // RULE1
        ##1 pllDivideRatio == (($past(odiv) == 3'h7) ? 9'h100
                               : 9'h001 << $past(odiv)))
        else $error("pll divide ratio does not match code");
    chk_top_zero: assert property ( // RULE2
        accept && !hwrite && rBlk == OFS_OSC_CTRL[15:4]
        |=> hrdata[31:30] == 2'h0)
        else $error("control bits 31:30 read nonzero");
    chk_clr_alias: assert property ( // RULE3
        s_oscAlias(AL_CLR) |=> !sleepOnWaitEnable)
        else $error("clear alias did not clear");
    chk_set_alias: assert property ( // RULE3
        s_oscAlias(AL_SET) |=> sleepOnWaitEnable)
        else $error("set alias did not set");
    chk_por_load: assert property ( // RULE5
        cfgLoad_q && powerOnReset |=>
        pllMultiplier == $past(cfgPllMultiplier)
        && periphBusClockDivisor == $past(cfgPeriphBusClockDivisor))
        else $error("power-on load missed configuration");
    chk_usb_absent: assert property ( // RULE6
        !HAS_USB |-> !usbFastRcEnable)
        else $error("usb enable set on part without usb");
    chk_fail_flag: assert property ( // RULE13
        failPulse |=> oscCtl_q[P_CF] ##0 stat_q[IRQ_FAIL])
        else $error("failure not flagged");
    chk_pb_guard: assert property ( // RULE14
        wrOsc && !pbRdy |=> $stable(periphBusClockDivisor))
        else $error("divisor changed while not ready");
    chk_req_clear: assert property ( // RULE11
        swIf.done && !(wrOsc && oscNew[P_SOURCE_SWITCH_REQUEST])
        |=> !oscCtl_q[P_SOURCE_SWITCH_REQUEST])
        else $error("switch request not cleared on completion");
endmodule

/* verilog/ocr_pkg.sv */
// constants and types for the oscillator configuration registers
package ocr_pkg;
    localparam int CLK_MHZ = 125;

    localparam logic [15:0] OFS_OSC_CTRL = 16'hf000;
    localparam logic [15:0] OFS_FRC_TUNE = 16'hf010;
    localparam logic [15:0] OFS_REF_CTRL = 16'hf020;
    localparam logic [15:0] OFS_REF_TRIM = 16'hf030;
    localparam logic [15:0] OFS_IRQ_STAT = 16'hf040;
    localparam logic [15:0] OFS_IRQ_MASK = 16'hf050;

    localparam logic [1:0] AL_PLAIN = 2'h0;
    localparam logic [1:0] AL_CLR   = 2'h1;
    localparam logic [1:0] AL_SET   = 2'h2;
    localparam logic [1:0] AL_INV   = 2'h3;

    localparam int P_PLL_OUTPUT_DIVIDER = 27;
    localparam int P_FAST_RC_DIVIDER  = 24;
    localparam int P_SECONDARY_OSC_READY = 22;
    localparam int P_PBRDY   = 21;
    localparam int P_PERIPH_BUS_CLOCK_DIVISOR   = 19;
    localparam int P_PLL_MULTIPLIER = 16;
    localparam int P_CURRENT_SOURCE_SELECT    = 12;
    localparam int P_NEW_SOURCE_SELECT    = 8;
    localparam int P_LOCK    = 7;
    localparam int P_USB_PLL_LOCK_STATUS   = 6;
    localparam int P_PLL_LOCK_STATUS   = 5;
    localparam int P_SLEEP_ON_WAIT_ENABLE   = 4;
    localparam int P_CF      = 3;
    localparam int P_UFRC    = 2;
    localparam int P_SECONDARY_OSC_ENABLE  = 1;
    localparam int P_SOURCE_SWITCH_REQUEST   = 0;
    localparam int P_REFCLK_DIVISOR   = 16;
    localparam int P_RON     = 15;
    localparam int P_RSIDL   = 13;
    localparam int P_ROE     = 12;
    localparam int P_RRSLP   = 11;
    localparam int P_DIVSW   = 9;
    localparam int P_ACTIVE  = 8;
    localparam int P_REFCLK_TRIM  = 23;

    localparam logic [31:0] OSC_WMASK  = 32'h3f1f_079f;
    localparam logic [31:0] LOCK_MASK  = 32'h3807_0701;
    localparam logic [31:0] PERIPH_BUS_CLOCK_DIVISOR_MASK = 32'h0018_0000;
    localparam logic [31:0] TUNE_WMASK = 32'h0000_003f;
    localparam logic [31:0] REF_WMASK  = 32'h7fff_ba0f;
    localparam logic [31:0] TRIM_WMASK = 32'hff80_0000;
    localparam logic [31:0] REG_RST    = 32'h0000_0000;

    localparam logic [2:0] RST_PLL_OUTPUT_DIVIDER = 3'h1;
    localparam logic [2:0] RST_FAST_RC_DIVIDER  = 3'h1;
    localparam logic [1:0] RST_PERIPH_BUS_CLOCK_DIVISOR   = 2'h3;
    localparam logic [2:0] RST_PLL_MULTIPLIER = 3'h0;

    localparam logic [2:0] SRC_FRC     = 3'h0;
    localparam logic [2:0] SRC_FRC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRI     = 3'h2;
    localparam logic [2:0] SRC_PRI_PLL = 3'h3;
    localparam logic [2:0] SRC_SEC     = 3'h4;
    localparam logic [2:0] SRC_LPRC    = 3'h5;
    localparam logic [2:0] SRC_FRC16   = 3'h6;
    localparam logic [2:0] SRC_FRC_DIV = 3'h7;

    localparam int SETTLE_NS  = 200;
    localparam int PB_NS      = 64;
    localparam int FAIL_NS    = 2000;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int PB_CYC     = (PB_NS * CLK_MHZ + 999) / 1000;
    localparam int FAIL_CYC   = (FAIL_NS * CLK_MHZ + 999) / 1000;

    localparam int IRQ_SWITCH = 0;
    localparam int IRQ_FAIL   = 1;

    typedef enum logic [1:0] {
        SW_IDLE   = 2'b00,
        SW_LOCK   = 2'b01,
        SW_SETTLE = 2'b11,
        SW_DONE   = 2'b10
    } ocr_sw_state_e;
endpackage

/* verilog/ocr_src_switch.sv */
// clock source switch sequencer holding the current source
module ocr_src_switch #(
    parameter int SETTLE_CYC = ocr_pkg::SETTLE_CYC
)(
    input wire logic      clk_sys,
    input wire logic      rst_b,
    ocr_switch_if.seq     sw
);
    import ocr_pkg::*;
    localparam int CW = $clog2(SETTLE_CYC + 1);

    if (SETTLE_CYC < 1) begin : g_bad
        $error("settle count must be at least one");
    end

    ocr_sw_state_e   state_q;
    ocr_sw_state_e   state_d;
    logic [CW-1:0]   cnt_q;
    logic [2:0]      tgt_q;
    logic [2:0]      cur_q;

    wire needPll = (tgt_q == SRC_FRC_PLL) || (tgt_q == SRC_PRI_PLL);
    wire settled = cnt_q == CW'(SETTLE_CYC - 1);
    wire idle    = state_q == SW_IDLE;

    // RULE10 switch sequence steps
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SW_IDLE:   if (sw.start) state_d = SW_LOCK;
            SW_LOCK:   if (!needPll || sw.pllLocked) state_d = SW_SETTLE;
            SW_SETTLE: if (settled) state_d = SW_DONE;
            SW_DONE:   state_d = SW_IDLE;
        endcase
        if (sw.failover || sw.load) state_d = SW_IDLE;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= SW_IDLE;
            cnt_q   <= '0;
            tgt_q   <= SRC_FRC;
        end else begin
            state_q <= state_d;
            cnt_q   <= (state_q == SW_SETTLE) ? cnt_q + 1'b1 : '0;
            if (idle && sw.start) tgt_q <= sw.target;
        end
    end

    // RULE16 current source moves on completion, on failover to frc, or on configuration load
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) cur_q <= SRC_FRC;
        else if (sw.load) cur_q <= sw.loadSrc;
        else if (sw.failover) cur_q <= SRC_FRC;
        else if (state_q == SW_DONE) cur_q <= tgt_q;
    end

    assign sw.busy   = !idle;
    assign sw.done   = state_q == SW_DONE;
    assign sw.curSrc = cur_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    chk_cur_steady: assert property ( // RULE16
        !sw.done && !sw.failover && !sw.load |=> $stable(cur_q))
        else $error("current source changed without a switch");
    chk_lock_wait: assert property ( // RULE10
        state_q == SW_LOCK && needPll && !sw.pllLocked
        && !sw.failover && !sw.load |=> state_q == SW_LOCK)
        else $error("switch left lock wait before pll lock");
endmodule

/* verilog/ocr_switch_if.sv */
// link between register front end and source switch sequencer
interface ocr_switch_if;
    logic       start;
    logic       failover;
    logic       pllLocked;
    logic       load;
    logic [2:0] target;
    logic [2:0] loadSrc;
    logic       busy;
    logic       done;
    logic [2:0] curSrc;
    modport ctrl (output start, failover, pllLocked, load, target,
                  loadSrc, input busy, done, curSrc);
    modport seq (input start, failover, pllLocked, load, target,
                 loadSrc, output busy, done, curSrc);
endinterface
